// file: rtl/mhp_params.svh
// constants of the management host port: pin levels, timing and counts
// assumes ref_clk is the transmit interface clock at 20 MHz
`ifndef MHP_PARAMS_SVH
`define MHP_PARAMS_SVH

// ------------------------------------------------------------
// widths and levels
// ------------------------------------------------------------
`define MHP_ADDR_W        7
`define MHP_DATA_W        8
`define MHP_BUS_IDLE      8'hFF
`define MHP_PULLUP        1'b1

// ------------------------------------------------------------
// timing (ns) and derived cycle counts
// ------------------------------------------------------------
`define MHP_CLK_PERIOD_NS 50
`define MHP_RST_LOW_NS    1000
`define MHP_RESP_TMO_NS   10000
// least time: round up
`define MHP_RST_CYC       ((`MHP_RST_LOW_NS + `MHP_CLK_PERIOD_NS - 1) / `MHP_CLK_PERIOD_NS)
// longest wait: round down
`define MHP_TMO_CYC       (`MHP_RESP_TMO_NS / `MHP_CLK_PERIOD_NS)
`define MHP_CNT_W         8

`endif

// file: rtl/mhp_pkg.sv
// types shared by both ends of the management host port
// assumes mhp_params.svh for all numeric constants
`include "mhp_params.svh"

package mhp_pkg;

	// ------------------------------------------------------------
	// device end states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DV_IDLE   = 3'h1,
		DV_FETCH  = 3'h2,
		DV_ANSWER = 3'h4
	} mhp_dev_state_t;

	// ------------------------------------------------------------
	// host end states
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		HS_RESET   = 6'h01,
		HS_IDLE    = 6'h02,
		HS_SETUP   = 6'h04,
		HS_STROBE  = 6'h08,
		HS_RELEASE = 6'h10
	} mhp_host_state_t;

	typedef logic [`MHP_ADDR_W-1:0] mhp_addr_t;
	typedef logic [`MHP_DATA_W-1:0] mhp_data_t;
	typedef logic [`MHP_CNT_W-1:0]  mhp_cnt_t;

endpackage

// file: rtl/mhp_bus_if.sv
// pins between host and device of the management host port
// the three-state lines are resolved here from the drive enables
`timescale 1ns/1ps
`include "mhp_params.svh"

interface mhp_bus_if;
	logic                   host_convention_select; // 1: rd/wr/ready, 0: ds/rw/ack
	logic [`MHP_ADDR_W-1:0] reg_addr_in;            // register number
	logic                   cs_n;                   // chip select
	logic                   data_strobe_n;          // data strobe or read strobe
	logic                   rw_wr_n;                // direction or write strobe
	logic [`MHP_DATA_W-1:0] host_do;                // host data drive
	logic                   host_oe_n;              // host data enable
	logic [`MHP_DATA_W-1:0] dev_do;                 // device data drive
	logic                   dev_oe_n;               // device data enable
	logic                   resp_out;               // ack or ready level
	logic                   resp_oe_n;              // response enable
	logic                   host_irq_n;             // interrupt to host
	logic                   sys_rst_n;              // system reset to device
	wire  [`MHP_DATA_W-1:0] reg_data_io;            // resolved data bus
	wire                    resp_n;                 // resolved response line

	// undriven lines float to the pull-up level
	assign reg_data_io = !dev_oe_n ? dev_do : (!host_oe_n ? host_do : `MHP_BUS_IDLE);
	assign resp_n      = !resp_oe_n ? resp_out : `MHP_PULLUP;

	modport dev (
		input  host_convention_select, reg_addr_in, cs_n, data_strobe_n,
		input  rw_wr_n, reg_data_io,
		output dev_do, dev_oe_n, resp_out, resp_oe_n, host_irq_n
	);

	modport host (
		output host_convention_select, reg_addr_in, cs_n, data_strobe_n,
		output rw_wr_n, host_do, host_oe_n, sys_rst_n,
		input  reg_data_io, resp_n, host_irq_n
	);
endinterface

// file: rtl/mhp_device.sv
// device end of the management host port
// assumes the register array behind it answers ureg_rdata in the same cycle as ureg_rd_req
`timescale 1ns/1ps
`include "mhp_params.svh"

module mhp_device
	import mhp_pkg::*;
(
	input  wire logic      ref_clk,     // transmit interface clock
	input  wire logic      rst_n,       // async reset, tie to bus.sys_rst_n
	mhp_bus_if.dev         bus,         // host pins
	output logic           ureg_rd_req, // read request pulse
	output logic           ureg_wr_req, // write request pulse
	output mhp_addr_t      ureg_addr,   // register number
	output mhp_data_t      ureg_wdata,  // write data
	input  wire mhp_data_t ureg_rdata,  // read data, same cycle as request
	input  wire mhp_data_t irq_src      // internal interrupt sources
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	mhp_dev_state_t state_r, state_nxt;
	logic      rd_r, rd_nxt;
	logic      rdreq_r, rdreq_nxt;
	logic      wrreq_r, wrreq_nxt;
	mhp_addr_t addr_r, addr_nxt;
	mhp_data_t wdata_r, wdata_nxt;
	mhp_data_t do_r, do_nxt;
	logic      oe_n_r, oe_n_nxt;
	logic      resp_r, resp_nxt;
	logic      resp_oe_n_r, resp_oe_n_nxt;
	logic      irq_n_r, irq_n_nxt;
	logic      act;
	logic      is_rd;

	// strobe decode per convention; cs high masks every strobe
	always_comb begin
		if (bus.host_convention_select) begin
			act   = ~bus.data_strobe_n | ~bus.rw_wr_n;
			is_rd = ~bus.data_strobe_n;
		end else begin
			act   = ~bus.data_strobe_n;
			is_rd = bus.rw_wr_n;
		end
		act = act & ~bus.cs_n;
	end

	// access sequence: take, fetch, answer until strobe is released
	always_comb begin
		state_nxt     = state_r;
		rd_nxt        = rd_r;
		rdreq_nxt     = 1'b0;
		wrreq_nxt     = 1'b0;
		addr_nxt      = addr_r;
		wdata_nxt     = wdata_r;
		do_nxt        = do_r;
		oe_n_nxt      = oe_n_r;
		resp_nxt      = resp_r;
		resp_oe_n_nxt = bus.cs_n;
		irq_n_nxt     = ~(|irq_src);
		case (state_r)
			DV_IDLE: begin
				oe_n_nxt = 1'b1;
				resp_nxt = 1'b1;
				if (act) begin
					addr_nxt  = bus.reg_addr_in;
					rd_nxt    = is_rd;
					rdreq_nxt = is_rd;
					wrreq_nxt = ~is_rd;
					wdata_nxt = bus.reg_data_io;
					state_nxt = DV_FETCH;
				end
			end
			DV_FETCH: begin
				do_nxt    = ureg_rdata;
				oe_n_nxt  = ~(rd_r & ~bus.cs_n);
				resp_nxt  = ~act;
				state_nxt = DV_ANSWER;
			end
			DV_ANSWER: begin
				if (!act) begin
					oe_n_nxt  = 1'b1;
					resp_nxt  = 1'b1;
					state_nxt = DV_IDLE;
				end
			end
			default: begin
				oe_n_nxt  = 1'b1;
				resp_nxt  = 1'b1;
				state_nxt = DV_IDLE;
			end
		endcase
	end

	// registers only; the bus is released at reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= DV_IDLE;
			rd_r        <= 1'b0;
			rdreq_r     <= 1'b0;
			wrreq_r     <= 1'b0;
			addr_r      <= '0;
			wdata_r     <= '0;
			do_r        <= '0;
			oe_n_r      <= 1'b1;
			resp_r      <= 1'b1;
			resp_oe_n_r <= 1'b1;
			irq_n_r     <= 1'b1;
		end else begin
			state_r     <= state_nxt;
			rd_r        <= rd_nxt;
			rdreq_r     <= rdreq_nxt;
			wrreq_r     <= wrreq_nxt;
			addr_r      <= addr_nxt;
			wdata_r     <= wdata_nxt;
			do_r        <= do_nxt;
			oe_n_r      <= oe_n_nxt;
			resp_r      <= resp_nxt;
			resp_oe_n_r <= resp_oe_n_nxt;
			irq_n_r     <= irq_n_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign bus.dev_do     = do_r;
	assign bus.dev_oe_n   = oe_n_r;
	assign bus.resp_out   = resp_r;
	assign bus.resp_oe_n  = resp_oe_n_r;
	assign bus.host_irq_n = irq_n_r;
	assign ureg_rd_req    = rdreq_r;
	assign ureg_wr_req    = wrreq_r;
	assign ureg_addr      = addr_r;
	assign ureg_wdata     = wdata_r;

endmodule

// file: rtl/mhp_host.sv
// host end of the management host port: drives register accesses
// assumes the device is clocked by the same ref_clk and reset by sys_rst_n
`timescale 1ns/1ps
`include "mhp_params.svh"

// Function
// - static pin picks strobe convention
// - host presents register number each access
// - one shared three-state 8-bit data bus
// - access only while chip select low
// - direction high read, low write
// - data strobe marks each access
// - read strobe requests a read
// - write strobe requests a write
// - device answers ack/ready; host waits
// - interrupt low when source detected
// - reset held low at least 1 us
// - reset time counted after supply good
// - line clocks run during reset; par_clk_run is held low while rst_n is low, even with par_mode set
// - transmit clock at 20 MHz minimum
module mhp_host
	import mhp_pkg::*;
(
	input  wire logic      ref_clk,        // 20 MHz transmit interface clock
	input  wire logic      rst_n,          // async reset of the host end
	mhp_bus_if.host        bus,            // device pins
	input  wire logic      conv_select,    // 1: rd/wr/ready, 0: ds/rw/ack
	input  wire logic      supply_ok,      // supply above 90 percent
	input  wire logic      par_mode,       // parallel line interface in use
	input  wire logic      cmd_valid,      // access request
	input  wire logic      cmd_write,      // 1 write, 0 read
	input  wire mhp_addr_t cmd_addr,       // register number
	input  wire mhp_data_t cmd_wdata,      // write data
	output logic           cmd_ready,      // request may be taken
	output logic           rsp_valid,      // access done pulse
	output logic           rsp_err,        // no answer before timeout
	output mhp_data_t      rsp_rdata,      // read data
	output logic           irq_pending,    // device interrupt seen
	output logic           line_clk_run,   // tx/rx interface clocks on
	output logic           par_clk_run     // parallel line clocks on
);

	// ------------------------------------------------------------
	// counts
	// ------------------------------------------------------------
	// ref_clk must be at least 20 MHz; both counts assume that period
	localparam mhp_cnt_t RST_LAST = mhp_cnt_t'(`MHP_RST_CYC - 1);
	localparam mhp_cnt_t TMO_LAST = mhp_cnt_t'(`MHP_TMO_CYC - 1);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	mhp_host_state_t state_r, state_nxt;
	mhp_cnt_t  cnt_r, cnt_nxt;
	logic      srst_n_r, srst_n_nxt;
	logic      conv_r, conv_nxt;
	logic      cs_n_r, cs_n_nxt;
	logic      stb_n_r, stb_n_nxt;
	logic      rw_r, rw_nxt;
	mhp_addr_t addr_r, addr_nxt;
	mhp_data_t hdo_r, hdo_nxt;
	logic      hoe_n_r, hoe_n_nxt;
	logic      rd_r, rd_nxt;
	logic      ready_r, ready_nxt;
	logic      rvld_r, rvld_nxt;
	logic      err_r, err_nxt;
	mhp_data_t rdata_r, rdata_nxt;
	logic      irq_r, irq_nxt;
	logic      lclk_r, lclk_nxt;
	logic      pclk_r, pclk_nxt;

	// reset pulse, then request / setup / strobe / release
	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		srst_n_nxt = srst_n_r;
		conv_nxt   = conv_r;
		cs_n_nxt   = cs_n_r;
		stb_n_nxt  = stb_n_r;
		rw_nxt     = rw_r;
		addr_nxt   = addr_r;
		hdo_nxt    = hdo_r;
		hoe_n_nxt  = hoe_n_r;
		rd_nxt     = rd_r;
		ready_nxt  = ready_r;
		rvld_nxt   = 1'b0;
		err_nxt    = err_r;
		rdata_nxt  = rdata_r;
		irq_nxt    = ~bus.host_irq_n;
		lclk_nxt   = 1'b1;
		pclk_nxt   = par_mode;
		case (state_r)
			HS_RESET: begin
				srst_n_nxt = 1'b0;
				conv_nxt   = conv_select; // strap caught while device held
				if (!supply_ok) begin
					cnt_nxt = '0;
				end else if (cnt_r == RST_LAST) begin
					srst_n_nxt = 1'b1;
					ready_nxt  = 1'b1;
					state_nxt  = HS_IDLE;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			HS_IDLE: begin
				if (cmd_valid && ready_r) begin
					ready_nxt = 1'b0;
					addr_nxt  = cmd_addr;
					rd_nxt    = ~cmd_write;
					hdo_nxt   = cmd_wdata;
					hoe_n_nxt = ~cmd_write;
					cs_n_nxt  = 1'b0;
					// separate strobes idle high; direction set ahead of strobe
					rw_nxt    = conv_r ? 1'b1 : ~cmd_write;
					state_nxt = HS_SETUP;
				end
			end
			HS_SETUP: begin
				cnt_nxt = '0;
				if (!conv_r) begin
					stb_n_nxt = 1'b0;
				end else if (rd_r) begin
					stb_n_nxt = 1'b0;
				end else begin
					rw_nxt = 1'b0;
				end
				state_nxt = HS_STROBE;
			end
			HS_STROBE: begin
				if (!bus.resp_n) begin
					rdata_nxt = bus.reg_data_io;
					err_nxt   = 1'b0;
					stb_n_nxt = 1'b1;
					rw_nxt    = conv_r ? 1'b1 : rw_r;
					state_nxt = HS_RELEASE;
				end else if (cnt_r == TMO_LAST) begin
					err_nxt   = 1'b1;
					stb_n_nxt = 1'b1;
					rw_nxt    = conv_r ? 1'b1 : rw_r;
					state_nxt = HS_RELEASE;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			HS_RELEASE: begin
				// keep select until the answer is withdrawn
				if (bus.resp_n) begin
					cs_n_nxt  = 1'b1;
					hoe_n_nxt = 1'b1;
					rvld_nxt  = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = HS_IDLE;
				end
			end
			default: begin
				cs_n_nxt  = 1'b1;
				stb_n_nxt = 1'b1;
				rw_nxt    = 1'b1;
				hoe_n_nxt = 1'b1;
				ready_nxt = 1'b0;
				cnt_nxt   = '0;
				state_nxt = HS_RESET;
			end
		endcase
	end

	// registers only; device held in reset from our own reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r  <= HS_RESET;
			cnt_r    <= '0;
			srst_n_r <= 1'b0;
			conv_r   <= 1'b0;
			cs_n_r   <= 1'b1;
			stb_n_r  <= 1'b1;
			rw_r     <= 1'b1;
			addr_r   <= '0;
			hdo_r    <= '0;
			hoe_n_r  <= 1'b1;
			rd_r     <= 1'b0;
			ready_r  <= 1'b0;
			rvld_r   <= 1'b0;
			err_r    <= 1'b0;
			rdata_r  <= '0;
			irq_r    <= 1'b0;
			lclk_r   <= 1'b1;
			pclk_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			srst_n_r <= srst_n_nxt;
			conv_r   <= conv_nxt;
			cs_n_r   <= cs_n_nxt;
			stb_n_r  <= stb_n_nxt;
			rw_r     <= rw_nxt;
			addr_r   <= addr_nxt;
			hdo_r    <= hdo_nxt;
			hoe_n_r  <= hoe_n_nxt;
			rd_r     <= rd_nxt;
			ready_r  <= ready_nxt;
			rvld_r   <= rvld_nxt;
			err_r    <= err_nxt;
			rdata_r  <= rdata_nxt;
			irq_r    <= irq_nxt;
			lclk_r   <= lclk_nxt;
			pclk_r   <= pclk_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign bus.host_convention_select = conv_r;
	assign bus.reg_addr_in            = addr_r;
	assign bus.cs_n                   = cs_n_r;
	assign bus.data_strobe_n          = stb_n_r;
	assign bus.rw_wr_n                = rw_r;
	assign bus.host_do                = hdo_r;
	assign bus.host_oe_n              = hoe_n_r;
	assign bus.sys_rst_n              = srst_n_r;
	assign cmd_ready                  = ready_r;
	assign rsp_valid                  = rvld_r;
	assign rsp_err                    = err_r;
	assign rsp_rdata                  = rdata_r;
	assign irq_pending                = irq_r;
	assign line_clk_run               = lclk_r;
	assign par_clk_run                = pclk_r;

endmodule

// file: testbench/mhp_port_sva.sv
// checker on the pins between host end and device end
// assumes one ref_clk domain; placed beside the bus interface
`timescale 1ns/1ps
`include "mhp_params.svh"

module mhp_port_sva (
	input wire logic                   ref_clk,                // port clock
	input wire logic                   rst_n,                  // host reset
	input wire logic                   sys_rst_n,              // device reset
	input wire logic                   host_convention_select, // strobe style
	input wire logic                   cs_n,                   // chip select
	input wire logic                   data_strobe_n,          // ds or rd strobe
	input wire logic                   rw_wr_n,                // direction or wr
	input wire logic [`MHP_ADDR_W-1:0] reg_addr_in,            // register number
	input wire logic [`MHP_DATA_W-1:0] host_do,                // host data
	input wire logic                   host_oe_n,              // host enable
	input wire logic                   dev_oe_n,               // device enable
	input wire logic                   resp_oe_n,              // response enable
	input wire logic                   resp_n                  // response line
);
	// ------------------------------------------------------------
	// helper: edges seen with the device in reset
	// ------------------------------------------------------------
	logic [4:0] low_r;
	logic [4:0] low_nxt;

	// saturates so a long reset never wraps to a short count
	always_comb low_nxt = sys_rst_n ? 5'h00 : (low_r == 5'h1F ? low_r : low_r + 5'h01);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) low_r <= 5'h00;
		else low_r <= low_nxt;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!sys_rst_n);

	// mode 0 only falls on the data strobe; direction may move with select
	sequence s_strobe_on;
		!cs_n && ($fell(data_strobe_n) || (host_convention_select && $fell(rw_wr_n)));
	endsequence
	sequence s_read_ans;
		##2 (!resp_n && !dev_oe_n);
	endsequence
	sequence s_write_ans;
		##2 (!resp_n && dev_oe_n);
	endsequence
	sequence s_released;
		data_strobe_n && (!host_convention_select || rw_wr_n);
	endsequence

	a_read_answer: assert property (s_strobe_on ##0 rw_wr_n |-> s_read_ans)
		else $error("read not answered with data");
	a_write_answer: assert property (s_strobe_on ##0 !rw_wr_n |-> s_write_ans)
		else $error("write not acknowledged");
	a_answer_ends: assert property (!resp_n ##0 s_released |=> resp_n && dev_oe_n)
		else $error("answer outlived the strobe");
	a_resp_floats: assert property (cs_n |=> resp_oe_n)
		else $error("response driven while unselected");
	a_data_floats: assert property (cs_n |=> dev_oe_n)
		else $error("data driven while unselected");
	a_write_no_drive: assert property (!host_oe_n |-> dev_oe_n)
		else $error("bus fight during write");
	a_select_held: assert property (!resp_n |-> !cs_n)
		else $error("select dropped during answer");
	a_addr_steady: assert property (!cs_n ##1 !cs_n |-> $stable(reg_addr_in))
		else $error("address moved in access");
	a_wdata_steady: assert property (!host_oe_n ##1 !host_oe_n |-> $stable(host_do))
		else $error("write data moved in access");
	a_reset_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(sys_rst_n) |-> low_r >= 5'h14)
		else $error("device reset too short");
endmodule

// file: testbench/mgmt_host_register_port_tb.sv
// bench joining host end and device end across the bus interface
// assumes ref_clk 50 ns; a second device on a bench-driven bus
`timescale 1ns/1ps
`include "mhp_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module mgmt_host_register_port_tb
	import mhp_pkg::*;
;
	logic ref_clk = 1'b0, rst_n = 1'b0, conv_select = 1'b0, supply_ok = 1'b0;
	logic par_mode = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0;
	mhp_addr_t cmd_addr = 7'h00;
	mhp_data_t cmd_wdata = 8'h00, irq_src = 8'h00;
	logic cmd_ready, rsp_valid, rsp_err, irq_pending, line_clk_run, par_clk_run;
	logic ureg_rd_req, ureg_wr_req, rd2, wr2;
	mhp_data_t rsp_rdata, ureg_wdata, ureg_rdata;
	mhp_addr_t ureg_addr;
	mhp_data_t mem [128];
	mhp_addr_t at [3] = '{7'h00, 7'h2A, 7'h7F};
	mhp_data_t dt [3] = '{8'hA5, 8'h00, 8'h3C};
	int n_errors = 0, cmp_count = 0, cyc = 0, hits2 = 0;

	mhp_bus_if bus ();
	mhp_bus_if bus2 ();

	mhp_host u_mhp_host (.ref_clk, .rst_n, .bus(bus), .conv_select, .supply_ok,
		.par_mode, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready,
		.rsp_valid, .rsp_err, .rsp_rdata, .irq_pending, .line_clk_run, .par_clk_run);
	mhp_device u_mhp_device (.ref_clk, .rst_n(bus.sys_rst_n), .bus(bus), .ureg_rd_req,
		.ureg_wr_req, .ureg_addr, .ureg_wdata, .ureg_rdata, .irq_src);
	// second device: the bench breaks the select rule on its bus
	mhp_device u_mhp_device_b (.ref_clk, .rst_n(bus2.sys_rst_n), .bus(bus2),
		.ureg_rd_req(rd2), .ureg_wr_req(wr2), .ureg_addr(), .ureg_wdata(),
		.ureg_rdata(8'h5A), .irq_src(8'h00));
	mhp_port_sva u_mhp_port_sva (.ref_clk, .rst_n, .sys_rst_n(bus.sys_rst_n),
		.host_convention_select(bus.host_convention_select), .cs_n(bus.cs_n),
		.data_strobe_n(bus.data_strobe_n), .rw_wr_n(bus.rw_wr_n),
		.reg_addr_in(bus.reg_addr_in), .host_do(bus.host_do), .host_oe_n(bus.host_oe_n),
		.dev_oe_n(bus.dev_oe_n), .resp_oe_n(bus.resp_oe_n), .resp_n(bus.resp_n));

	// ------------------------------------------------------------
	// clock, register array, watchdog
	// ------------------------------------------------------------
	always #25 ref_clk = ~ref_clk;
	// combinational read keeps data valid in the same cycle as the request
	assign ureg_rdata = mem[ureg_addr];
	always @(posedge ref_clk) begin
		if (ureg_wr_req) mem[ureg_addr] <= ureg_wdata;
		if (rd2 || wr2) hits2++;
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			results();
		end
	end

	task automatic results();
		if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// leaves the bench one ns after a rising edge
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	// one host access; reads are compared with the expected byte
	task automatic acc(input logic wr, input mhp_addr_t a, input mhp_data_t d);
		int n;
		n = 0;
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = a;
		cmd_wdata = d;
		while (cmd_ready !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
		tick(1);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		`CHK("rsp_valid", 1'b1, rsp_valid)
		`CHK("rsp_err", 1'b0, rsp_err)
		if (!wr) `CHK("rsp_rdata", d, rsp_rdata)
	endtask

	initial begin
		bus2.host_convention_select = 1'b0;
		bus2.reg_addr_in = 7'h05;
		bus2.cs_n = 1'b1;
		bus2.data_strobe_n = 1'b1;
		bus2.rw_wr_n = 1'b1;
		bus2.host_do = 8'h00;
		bus2.host_oe_n = 1'b1;
		bus2.sys_rst_n = 1'b0;
		tick(3);
		`CHK("line_clk", 1'b1, line_clk_run)
		`CHK("par_clk", 1'b0, par_clk_run)
		`CHK("cmd_ready", 1'b0, cmd_ready)
		rst_n = 1'b1;
		bus2.sys_rst_n = 1'b1;
		tick(5);
		`CHK("sys_rst", 1'b0, bus.sys_rst_n)
		`CHK("par_clk", 1'b1, par_clk_run)
		// a dip in the supply restarts the reset count
		supply_ok = 1'b1;
		tick(10);
		supply_ok = 1'b0;
		tick(1);
		supply_ok = 1'b1;
		tick(19);
		`CHK("sys_rst", 1'b0, bus.sys_rst_n)
		`CHK("cmd_ready", 1'b0, cmd_ready)
		tick(1);
		`CHK("sys_rst", 1'b1, bus.sys_rst_n)
		`CHK("cmd_ready", 1'b1, cmd_ready)
		// strobe with direction line, then separate strobes after a reset
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 3; i++) acc(1'b1, at[i], dt[i] ^ {8{m[0]}});
			for (int i = 2; i >= 0; i--) acc(1'b0, at[i], dt[i] ^ {8{m[0]}});
			if (m == 0) begin
				rst_n = 1'b0;
				conv_select = 1'b1;
				par_mode = 1'b0;
				tick(2);
				rst_n = 1'b1;
			end
		end
		`CHK("par_clk", 1'b0, par_clk_run)
		acc(1'b1, 7'h11, 8'hC3);
		acc(1'b0, 7'h11, 8'hC3);
		// interrupt follows the sources two cycles later
		irq_src = 8'h80;
		tick(1);
		`CHK("irq_pending", 1'b0, irq_pending)
		tick(1);
		`CHK("irq_pending", 1'b1, irq_pending)
		`CHK("irq_pin", 1'b0, bus.host_irq_n)
		irq_src = 8'h00;
		tick(2);
		`CHK("irq_pending", 1'b0, irq_pending)
		// strobe with select high must be ignored; then a proper read
		bus2.data_strobe_n = 1'b0;
		tick(4);
		`CHK("hits2", 0, hits2)
		`CHK("data2", 8'hFF, bus2.reg_data_io)
		`CHK("resp2", 1'b1, bus2.resp_n)
		bus2.data_strobe_n = 1'b1;
		bus2.cs_n = 1'b0;
		tick(1);
		bus2.data_strobe_n = 1'b0;
		tick(4);
		`CHK("hits2", 1, hits2)
		`CHK("data2", 8'h5A, bus2.reg_data_io)
		`CHK("resp2", 1'b0, bus2.resp_n)
		results();
	end
endmodule
